//--- ais_conv_model.sv
// Converter stand-in: answers a start with a one-cycle done pulse.
// Assumes the block's clock; delay is held until the pulse ends.
`timescale 1ns/1ps
module ais_conv_model (
    input  wire logic       clock,
    input  wire logic       start,
    input  wire logic [2:0] delay,
    output logic            conv_done
);
    initial conv_done = 1'b0;
    always @(posedge clock) begin
        if (start) begin
            repeat (delay) @(posedge clock);
            conv_done <= 1'b1;
            @(posedge clock);
            conv_done <= 1'b0;
        end
    end
endmodule : ais_conv_model

//--- ais_decode.sv
// Combinational decoder of one positive and one negative selector code.
// Assumes codes come from registers on the same clock.
`timescale 1ns/1ps
`include "ais_params.svh"
module ais_decode (
    ais_sel_if.dec sel
);

    function automatic ais_pkg::ais_neg_src_e neg_decode(
        input ais_pkg::ais_neg_code_t code
    );
        if (code == `AIS_NEG_CODE_VREF) begin
            neg_decode = ais_pkg::AIS_NEG_VREF;
        end else if (code == `AIS_NEG_CODE_AN1) begin
            neg_decode = ais_pkg::AIS_NEG_AN1;
        end else begin
            neg_decode = ais_pkg::AIS_NEG_NONE;
        end
    endfunction : neg_decode

    wire [31:0] code_bit;
    wire        ltd_code;

    assign code_bit = 32'h0000_0001 << sel.pos_code;
    assign ltd_code = |(code_bit & `AIS_PKG_LTD_MASK);
    // Limited codes select nothing on small packages
    assign sel.pos_valid  = !(ltd_code && !sel.large_pkg); // R7
    assign sel.pos_onehot = sel.pos_valid ? code_bit : 32'h0000_0000; // R7
    assign sel.pos_no_buf = |(code_bit & `AIS_NO_BUF_MASK); // R6
    assign sel.neg_src    = neg_decode(sel.neg_code); // R8

endmodule : ais_decode

//--- ais_monitor.sv
// Concurrent checks on the pins of the input select block.
// Assumes a bind onto ais_top with one clock and a high reset.
`timescale 1ns/1ps
module ais_monitor (
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        pkg_large_pin,
    input wire logic        conv_done,
    input wire logic [31:0] mux_pos_onehot,
    input wire logic        mux_neg_vref,
    input wire logic        mux_neg_an1,
    input wire logic        mux_input_valid,
    input wire logic        result_wr_en,
    input wire logic        gap_ref_enable,
    input wire logic        gap_div2_enable,
    input wire logic        gap_div6_enable
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence s_cfg_wr;
        hsel && htrans[1] && hready && hwrite && haddr[7:2] == 6'h01 ##2 1'b1;
    endsequence
    AST_GAP_REF: assert property (s_cfg_wr |=> gap_ref_enable == $past(hwdata[0], 2))
        else $error("reference enable differs from written bit");
    AST_GAP_DIV2: assert property (s_cfg_wr |=> gap_div2_enable == $past(hwdata[1], 2))
        else $error("half enable differs from written bit");
    AST_GAP_DIV6: assert property (s_cfg_wr |=> gap_div6_enable == $past(hwdata[2], 2))
        else $error("sixth enable differs from written bit");
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    AST_NEG_ONE: assert property (mux_input_valid |-> mux_neg_vref ^ mux_neg_an1)
        else $error("valid input without one negative source");
    AST_POS_ONE: assert property (mux_input_valid |-> $onehot(mux_pos_onehot))
        else $error("valid input without one positive source");
    AST_PKG_LTD: assert property ((!pkg_large_pin) [*4] |-> mux_pos_onehot[23:16] == 8'h00)
        else $error("package limited input selected on small package");
    AST_WR_CAUSE: assert property (result_wr_en |-> $past(conv_done))
        else $error("result write without conversion");
    AST_WR_PULSE: assert property (result_wr_en && !conv_done |=> !result_wr_en)
        else $error("result write longer than one cycle");
    AST_NO_BUF: assert property (conv_done && $stable(mux_pos_onehot)
        && mux_pos_onehot[31:25] != 7'h00 |=> !result_wr_en)
        else $error("result write for bufferless source");
endmodule : ais_monitor

bind ais_top ais_monitor i_ais_monitor (.clock(clock), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .pkg_large_pin(pkg_large_pin), .conv_done(conv_done), .mux_pos_onehot(mux_pos_onehot),
    .mux_neg_vref(mux_neg_vref), .mux_neg_an1(mux_neg_an1), .mux_input_valid(mux_input_valid),
    .result_wr_en(result_wr_en), .gap_ref_enable(gap_ref_enable),
    .gap_div2_enable(gap_div2_enable), .gap_div6_enable(gap_div6_enable));

//--- ais_params.svh
// Offsets, field positions, reset values and code maps of the input select block.
// Assumes inclusion by bare name from the design modules.
`ifndef AIS_PARAMS_SVH
`define AIS_PARAMS_SVH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define AIS_ADDR_LSB      2
`define AIS_ADDR_MSB      7
`define AIS_SIS_OFFSET    8'h00
`define AIS_BGC_OFFSET    8'h04
`define AIS_STAT_OFFSET   8'h08

// ****************************************
// Reset values
// ****************************************
`define AIS_SIS_RESET     16'h0000
`define AIS_BGC_RESET     3'h0

// ****************************************
// Sample select fields
// ****************************************
`define AIS_B_NEG_MSB     15
`define AIS_B_NEG_LSB     13
`define AIS_B_POS_MSB     12
`define AIS_B_POS_LSB     8
`define AIS_A_NEG_MSB     7
`define AIS_A_NEG_LSB     5
`define AIS_A_POS_MSB     4
`define AIS_A_POS_LSB     0

// ****************************************
// Band gap config fields
// ****************************************
`define AIS_BGC_DIV6_BIT  2
`define AIS_BGC_DIV2_BIT  1
`define AIS_BGC_REF_BIT   0
`define AIS_BGC_W         3

// ****************************************
// Code maps
// ****************************************
`define AIS_NEG_CODE_VREF 3'h0
`define AIS_NEG_CODE_AN1  3'h2
`define AIS_NO_BUF_MASK   32'hfe00_0000
`define AIS_PKG_LTD_MASK  32'h00ff_0000

`endif

//--- ais_pkg.sv
// Types shared by the input select block.
// Assumes nothing of its surroundings.
package ais_pkg;

    typedef logic [4:0] ais_pos_code_t;
    typedef logic [2:0] ais_neg_code_t;

    typedef enum logic [1:0] {
        AIS_NEG_VREF,
        AIS_NEG_AN1,
        AIS_NEG_NONE
    } ais_neg_src_e;

    typedef enum logic [1:0] {
        AIS_PH_IDLE,
        AIS_PH_WRITE,
        AIS_PH_READ
    } ais_phase_e;

endpackage : ais_pkg

//--- ais_sel_if.sv
// Carrier between the register top and one selector decoder.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface ais_sel_if;
    ais_pkg::ais_pos_code_t pos_code;
    ais_pkg::ais_neg_code_t neg_code;
    logic                   large_pkg;
    logic [31:0]            pos_onehot;
    logic                   pos_valid;
    logic                   pos_no_buf;
    ais_pkg::ais_neg_src_e  neg_src;

    modport dec  (input  pos_code, neg_code, large_pkg,
                  output pos_onehot, pos_valid, pos_no_buf, neg_src);
    modport user (output pos_code, neg_code, large_pkg,
                  input  pos_onehot, pos_valid, pos_no_buf, neg_src);
endinterface : ais_sel_if

//--- ais_top.sv
// Sample input select and band gap reference configuration, AHB-Lite slave.
// Registers are one word each; unused upper bits read as zero.
// Assumes one 200 MHz clock, a single-master AHB-Lite bus, a static package strap pin.
// Sample set select and conversion done come from logic on this clock.
//
// Overview of operation
// R1: Bits 7..5 pick sample A negative input, coded like sample B's bits 15..13.
// R2: Bits 4..0 pick sample A positive input, coded like sample B's bits 12..8.
// R3: Config bit 2 set enables band gap divided by six; clear disables it.
// R4: Config bit 1 set enables band gap divided by two; clear disables it.
// R5: Config bit 0 set enables the undivided band gap reference.
// R6: High internal positive sources have no result buffer; never write one.
// R7: Package-limited inputs exist only on the large package; else select nothing.
// R8: Negative code 000 is reference, 010 is input one, others unimplemented.
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "ais_params.svh"
module ais_top (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        pkg_large_pin,
    input  wire logic        sample_set_b,
    input  wire logic        conv_done,
    output logic [31:0]      mux_pos_onehot,
    output logic             mux_neg_vref,
    output logic             mux_neg_an1,
    output logic             mux_input_valid,
    output logic             result_wr_en,
    output logic             gap_ref_enable,
    output logic             gap_div2_enable,
    output logic             gap_div6_enable
);

    // ****************************************
    // Declarations
    // ****************************************
    logic [15:0]            sis_q;
    logic [15:0]            sis_d;
    logic [2:0]             bgc_q;
    logic [2:0]             bgc_d;
    ais_pkg::ais_phase_e    phase_q;
    ais_pkg::ais_phase_e    phase_d;
    logic [7:0]             addr_q;
    logic [31:0]            rdata_q;
    logic [31:0]            rdata_d;
    logic                   strap_meta_q;
    logic                   strap_q;
    logic [31:0]            pos_q;
    logic                   neg_vref_q;
    logic                   neg_an1_q;
    logic                   valid_q;
    logic                   wr_en_q;
    logic [2:0]             gap_q;

    wire                    take;
    wire                    wr_sis;
    wire                    wr_bgc;
    wire [7:0]              rd_addr;
    wire [6:0]              status;
    wire                    act_valid;
    wire                    act_no_buf;
    ais_pkg::ais_neg_src_e  act_neg;
    wire [31:0]             act_pos;

    ais_sel_if sel_a ();
    ais_sel_if sel_b ();

    // ****************************************
    // Functions
    // ****************************************
    // A negative code is implemented when it names a real source
    function automatic logic neg_impl(
        input ais_pkg::ais_neg_src_e src
    );
        neg_impl = src != ais_pkg::AIS_NEG_NONE;
    endfunction : neg_impl

    // Arguments carry the bus state so continuous assigns track it
    function automatic logic write_hit(
        input ais_pkg::ais_phase_e phase,
        input logic [7:0]          addr,
        input logic [7:0]          offset
    );
        write_hit = (phase == ais_pkg::AIS_PH_WRITE) && (addr == offset);
    endfunction : write_hit

    // ****************************************
    // Bus address phase
    // ****************************************
    assign take    = hsel && htrans[1] && hready;
    assign rd_addr = {haddr[`AIS_ADDR_MSB:`AIS_ADDR_LSB], 2'b00};

    always_comb begin
        phase_d = ais_pkg::AIS_PH_IDLE;
        if (take) begin
            phase_d = hwrite ? ais_pkg::AIS_PH_WRITE : ais_pkg::AIS_PH_READ;
        end else if (!hready) begin
            phase_d = phase_q;
        end
    end

    // ****************************************
    // Register writes in data phase
    // ****************************************
    assign wr_sis = write_hit(phase_q, addr_q, `AIS_SIS_OFFSET);
    assign wr_bgc = write_hit(phase_q, addr_q, `AIS_BGC_OFFSET);

    // Both sample sets are written as one 16-bit word
    assign sis_d = wr_sis ? hwdata[15:0] : sis_q; // R1 R2
    // Only bits 2..0 exist; upper bits are dropped
    assign bgc_d = wr_bgc ? hwdata[`AIS_BGC_W-1:0] : bgc_q; // R3 R4 R5

    // ****************************************
    // Read data
    // ****************************************
    assign status = {strap_q,
                     sel_b.pos_no_buf,
                     neg_impl(sel_b.neg_src),
                     sel_b.pos_valid,
                     sel_a.pos_no_buf,
                     neg_impl(sel_a.neg_src),
                     sel_a.pos_valid};

    // Reads see a write still in its data phase
    always_comb begin
        rdata_d = rdata_q;
        if (take && !hwrite) begin
            unique case (rd_addr)
                `AIS_SIS_OFFSET:  rdata_d = {16'h0000, sis_d};
                `AIS_BGC_OFFSET:  rdata_d = {29'h0000_0000, bgc_d};
                `AIS_STAT_OFFSET: rdata_d = {25'h000_0000, status};
                default:          rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // Bus and register flops
    // ****************************************
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            phase_q <= ais_pkg::AIS_PH_IDLE;
        end else begin
            phase_q <= phase_d;
        end
    end

    // Address is kept for the data phase that follows
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            addr_q <= 8'h00;
        end else if (take) begin
            addr_q <= rd_addr;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sis_q <= `AIS_SIS_RESET;
        end else begin
            sis_q <= sis_d;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            bgc_q <= `AIS_BGC_RESET;
        end else begin
            bgc_q <= bgc_d;
        end
    end

    // Only whole-word transfers are expected; size is not checked
    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;

    // ****************************************
    // Package strap synchroniser
    // ****************************************
    // Strap is static; the flops only keep metastability out
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            strap_meta_q <= 1'b0;
            strap_q      <= 1'b0;
        end else begin
            strap_meta_q <= pkg_large_pin;
            strap_q      <= strap_meta_q;
        end
    end

    // ****************************************
    // Selector decoders
    // ****************************************
    assign sel_a.pos_code  = sis_q[`AIS_A_POS_MSB:`AIS_A_POS_LSB]; // R2
    assign sel_a.neg_code  = sis_q[`AIS_A_NEG_MSB:`AIS_A_NEG_LSB]; // R1
    assign sel_a.large_pkg = strap_q; // R7
    assign sel_b.pos_code  = sis_q[`AIS_B_POS_MSB:`AIS_B_POS_LSB];
    assign sel_b.neg_code  = sis_q[`AIS_B_NEG_MSB:`AIS_B_NEG_LSB];
    assign sel_b.large_pkg = strap_q;

    ais_decode u_dec_a (
        .sel (sel_a)
    );

    ais_decode u_dec_b (
        .sel (sel_b)
    );

    // ****************************************
    // Active sample set
    // ****************************************
    // Set choice reaches the pins one cycle after the select changes
    assign act_pos    = sample_set_b ? sel_b.pos_onehot : sel_a.pos_onehot;
    assign act_neg    = sample_set_b ? sel_b.neg_src : sel_a.neg_src;
    assign act_valid  = sample_set_b ? sel_b.pos_valid : sel_a.pos_valid;
    assign act_no_buf = sample_set_b ? sel_b.pos_no_buf : sel_a.pos_no_buf;

    // ****************************************
    // Multiplexer and reference outputs
    // ****************************************
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pos_q <= 32'h0000_0000;
        end else begin
            pos_q <= act_pos; // R7
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            neg_vref_q <= 1'b0;
        end else begin
            neg_vref_q <= act_neg == ais_pkg::AIS_NEG_VREF; // R8
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            neg_an1_q <= 1'b0;
        end else begin
            neg_an1_q <= act_neg == ais_pkg::AIS_NEG_AN1; // R8
        end
    end

    // Valid needs a usable positive and an implemented negative code
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            valid_q <= 1'b0;
        end else begin
            valid_q <= act_valid && neg_impl(act_neg); // R8
        end
    end

    // Reference enables trail the config register by one cycle
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            gap_q <= 3'h0;
        end else begin
            gap_q <= bgc_q;
        end
    end

    // ****************************************
    // Result write strobe
    // ****************************************
    // High internal positive sources never reach a result buffer
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wr_en_q <= 1'b0;
        end else begin
            wr_en_q <= conv_done && act_valid && !act_no_buf; // R6
        end
    end

    assign mux_pos_onehot  = pos_q;
    assign mux_neg_vref    = neg_vref_q;
    assign mux_neg_an1     = neg_an1_q;
    assign mux_input_valid = valid_q;
    assign result_wr_en    = wr_en_q;
    assign gap_div6_enable = gap_q[`AIS_BGC_DIV6_BIT]; // R3
    assign gap_div2_enable = gap_q[`AIS_BGC_DIV2_BIT]; // R4
    assign gap_ref_enable  = gap_q[`AIS_BGC_REF_BIT]; // R5

endmodule : ais_top

//--- tb_top.sv
// Self-checking bench of the input select block over AHB-Lite.
// Assumes ais_top, ais_monitor and ais_conv_model are compiled first.
`timescale 1ns/1ps
module tb_top;
    typedef struct {logic [1:0] sel; logic [31:0] exp;} ais_note_s;
    logic        clock = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic        sample_set_b = 1'b0, pkg_large_pin = 1'b0, start = 1'b0, look = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b010, delay = 3'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, mux_pos_onehot, seen, v;
    logic        hready, hreadyout, hresp, conv_done, mux_neg_vref, mux_neg_an1;
    logic        mux_input_valid, result_wr_en, gap_ref_enable, gap_div2_enable;
    logic        gap_div6_enable;
    int          miscompares = 0, total_checks = 0, cycles = 0, t;
    string       nm[4] = '{"hrdata", "onehot", "flags", "wr_en"};
    ais_note_s   notes[$], n;
    assign hready = hreadyout;
    always #2.5 clock = ~clock;
    ais_top i_ais_top (.clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pkg_large_pin(pkg_large_pin),
        .sample_set_b(sample_set_b), .conv_done(conv_done), .mux_pos_onehot(mux_pos_onehot),
        .mux_neg_vref(mux_neg_vref), .mux_neg_an1(mux_neg_an1),
        .mux_input_valid(mux_input_valid), .result_wr_en(result_wr_en),
        .gap_ref_enable(gap_ref_enable), .gap_div2_enable(gap_div2_enable),
        .gap_div6_enable(gap_div6_enable));
    ais_conv_model i_ais_conv_model (.clock(clock), .start(start), .delay(delay),
        .conv_done(conv_done));
    // ****************************************
    // Watcher and closing
    // ****************************************
    always @(posedge clock) begin
        if (look) begin
            n = notes.pop_front();
            seen = n.sel == 2'd0 ? hrdata : n.sel == 2'd1 ? mux_pos_onehot :
                n.sel == 2'd2 ? {26'h0, mux_input_valid, mux_neg_an1, mux_neg_vref,
                gap_div6_enable, gap_div2_enable, gap_ref_enable} : {31'h0, result_wr_en};
            total_checks++;
            if (seen !== n.exp) begin
                miscompares++;
                $display("wrong value %s expected %h seen %h", nm[n.sel], n.exp, seen);
            end
        end
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 8000) begin
            miscompares++;
            finish_test();
        end
    end
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    // ****************************************
    // Drivers
    // ****************************************
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        look <= !w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        look <= 1'b0;
    endtask : ahb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        notes.push_back('{2'd0, e});
        ahb(1'b0, a, 32'h0);
    endtask : rd
    task automatic chk(input logic [1:0] s, input logic [31:0] e);
        notes.push_back('{s, e});
        look <= 1'b1;
        @(posedge clock);
        look <= 1'b0;
        @(posedge clock);
    endtask : chk
    task automatic pick(input logic b, input logic [2:0] g, input logic [2:0] ng,
                        input logic [4:0] p);
        logic [7:0] j;
        logic       pv;
        j = 8'($urandom);
        pv = pkg_large_pin || p < 5'd16 || p > 5'd23;
        sample_set_b <= b;
        ahb(1'b1, 8'h00, b ? {16'h0, ng, p, j} : {16'h0, j, ng, p});
        repeat (2) @(posedge clock);
        chk(2'd1, pv ? 32'h1 << p : 32'h0);
        chk(2'd2, {26'h0, pv && (ng == 3'd0 || ng == 3'd2), ng == 3'd2, ng == 3'd0, g});
    endtask : pick
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        v = $urandom(43246);
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        chk(2'd2, 32'h0000_0028);
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        ahb(1'b1, 8'h08, 32'hffff_ffff);
        rd(8'h08, 32'h0000_001b);
        v = $urandom;
        ahb(1'b1, 8'h00, v);
        rd(8'h00, {16'h0, v[15:0]});
        ahb(1'b1, 8'h0c, v);
        rd(8'h0c, 32'h0);
        for (int i = 0; i < 8; i++) begin
            ahb(1'b1, 8'h04, {$urandom} << 3 | i);
            rd(8'h04, i);
            pick(1'b0, i[2:0], 3'd0, 5'd0);
        end
        for (int i = 0; i < 16; i++) pick(i[0], 3'd7, i[3:1], 5'($urandom));
        for (int i = 0; i < 64; i++) pick(i[0], 3'd7, 3'd2, i[5:1]);
        pkg_large_pin <= 1'b1;
        repeat (4) @(posedge clock);
        for (int i = 32; i < 48; i++) pick(i[0], 3'd7, 3'd0, i[5:1]);
        for (int k = 0; k < 12; k++) begin
            v = k < 2 ? 24 + k : $urandom_range(31, 0);
            pick(k[0], 3'd7, 3'd0, v[4:0]);
            delay <= 3'($urandom_range(5, 0));
            start <= 1'b1;
            @(posedge clock);
            start <= 1'b0;
            t = 0;
            do begin @(posedge clock); t++; end while (conv_done !== 1'b1 && t < 20);
            chk(2'd3, {31'h0, v < 25});
        end
        finish_test();
    end
endmodule : tb_top
